//--- core/wwdt_defs.vh
// Purpose: constants for the window watchdog timer
// Assumes: 125 MHz system clock
// Notes: counter is 7 bits, bit 6 low means timeout
`ifndef WWDT_DEFS_VH
`define WWDT_DEFS_VH
`define WWDT_CLK_MHZ 125
`define WWDT_REF_MHZ 16
`define WWDT_CNT_W 7
`define WWDT_T6_BIT 6
`define WWDT_CNT_RST 7'h7F
`define WWDT_WIN_RST 7'h7F
`define WWDT_PRE_BASE 12288
`define WWDT_TMO_MIN_US 75
`define WWDT_TMO_MAX_MS 64
`define WWDT_TICK_CYC ((`WWDT_PRE_BASE * `WWDT_CLK_MHZ + `WWDT_REF_MHZ - 1) / `WWDT_REF_MHZ)
`define WWDT_PRE_W 17
`endif

//--- core/wwdt_prescaler.v
// Purpose: tick generator for the watchdog downcounter
// Assumes: synchronous active-high reset
// Notes: one-cycle tick every TICK_CYC cycles while running
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_defs.vh"
module wwdt_prescaler
#(
  parameter [`WWDT_PRE_W-1:0] TICK_CYC = `WWDT_TICK_CYC
)
(
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Control
  input wire run,
  input wire restart,
  // Tick out
  output reg tick_ff
);
  reg [`WWDT_PRE_W-1:0] cnt_ff;
  reg [`WWDT_PRE_W-1:0] nxt_cnt;
  reg nxt_tick;

  always @*
  begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!run || restart)
    begin
      nxt_cnt = {`WWDT_PRE_W{1'b0}};
    end
    else if (cnt_ff == TICK_CYC - 1'b1)
    begin
      nxt_cnt = {`WWDT_PRE_W{1'b0}};
      nxt_tick = 1'b1;
    end
    else
    begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnt_ff <= {`WWDT_PRE_W{1'b0}};
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
endmodule
`default_nettype wire

//--- core/wwdt_top.v
// Purpose: window watchdog timer top
// Assumes: software writes arrive as one-cycle strobes with data
// Notes: reset request is a sticky level until system reset
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_defs.vh"
module wwdt_top
#(
  parameter [`WWDT_PRE_W-1:0] TICK_CYC = `WWDT_TICK_CYC
)
(
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Start-up configuration
  input wire cfg_hw_enable,
  // Software control writes
  input wire ctl_wr,
  input wire ctl_enable,
  input wire [`WWDT_CNT_W-1:0] ctl_count,
  input wire win_wr,
  input wire [`WWDT_CNT_W-1:0] win_value,
  // Status
  output reg active_ff,
  output reg [`WWDT_CNT_W-1:0] count_ff,
  output reg [`WWDT_CNT_W-1:0] window_ff,
  output reg reset_req_ff,
  output reg timeout_flag_ff,
  output reg early_flag_ff
);
  // Activation state
  reg strap_done_ff;
  reg nxt_strap_done;
  reg nxt_active;
  // Counter and window
  reg [`WWDT_CNT_W-1:0] nxt_count;
  reg [`WWDT_CNT_W-1:0] nxt_window;
  // Reset request and causes
  reg nxt_reset_req;
  reg nxt_timeout;
  reg nxt_early;
  // Decoded events
  wire tick;
  wire run;
  wire refresh;
  wire win_load;
  wire early;
  wire load_low;
  wire tick_low;
  wire expire;

  // Bit 6 low marks the timeout point
  function at_timeout;
    input [`WWDT_CNT_W-1:0] c;
    begin
      at_timeout = (c[`WWDT_T6_BIT] == 1'b0);
    end
  endfunction

  // Count not yet below the window value
  function too_early;
    input [`WWDT_CNT_W-1:0] c;
    input [`WWDT_CNT_W-1:0] w;
    begin
      too_early = (c >= w);
    end
  endfunction

  // All writes are dropped once a reset is requested
  assign refresh = ctl_wr && !reset_req_ff;
  assign win_load = win_wr && !reset_req_ff;
  assign run = active_ff && !reset_req_ff;
  assign early = refresh && active_ff && too_early(count_ff, window_ff);
  // A reload already below bit 6 is a timeout at once if the watchdog is active or enabled by the same write
  assign load_low = refresh && !early && nxt_active && at_timeout(ctl_count);
  // An in-time refresh on the tick edge wins over the timeout
  assign tick_low = run && tick && !refresh && at_timeout(count_ff - 1'b1);
  assign expire = load_low || tick_low;

  wwdt_prescaler #(.TICK_CYC(TICK_CYC)) u_pre
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(run),
    .restart(refresh),
    .tick_ff(tick)
  );

  // Strap is looked at only on the first edge after reset
  always @*
  begin
    nxt_strap_done = 1'b1;
    nxt_active = active_ff;
    if (!strap_done_ff && cfg_hw_enable)
    begin
      nxt_active = 1'b1;
    end
    if (refresh && ctl_enable)
    begin
      nxt_active = 1'b1;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      strap_done_ff <= 1'b0;
    end
    else
    begin
      strap_done_ff <= nxt_strap_done;
    end
  end

  // No path clears activation but system reset
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      active_ff <= 1'b0;
    end
    else
    begin
      active_ff <= nxt_active;
    end
  end

  always @*
  begin
    nxt_window = window_ff;
    if (win_load)
    begin
      nxt_window = win_value;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      window_ff <= `WWDT_WIN_RST;
    end
    else
    begin
      window_ff <= nxt_window;
    end
  end

  // Valid refresh reloads, otherwise one step per tick
  always @*
  begin
    nxt_count = count_ff;
    if (refresh && !early)
    begin
      nxt_count = ctl_count;
    end
    else if (run && tick)
    begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      count_ff <= `WWDT_CNT_RST;
    end
    else
    begin
      count_ff <= nxt_count;
    end
  end

  // Request and cause flags stand until system reset
  always @*
  begin
    nxt_reset_req = reset_req_ff;
    nxt_timeout = timeout_flag_ff;
    nxt_early = early_flag_ff;
    if (expire)
    begin
      nxt_reset_req = 1'b1;
      nxt_timeout = 1'b1;
    end
    if (early)
    begin
      nxt_reset_req = 1'b1;
      nxt_early = 1'b1;
    end
  end

  // Counting halts once this is set
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      reset_req_ff <= 1'b0;
    end
    else
    begin
      reset_req_ff <= nxt_reset_req;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      timeout_flag_ff <= 1'b0;
    end
    else
    begin
      timeout_flag_ff <= nxt_timeout;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      early_flag_ff <= 1'b0;
    end
    else
    begin
      early_flag_ff <= nxt_early;
    end
  end
endmodule
`default_nettype wire

//--- tb/wwdt_sva.sv
// Purpose: watchdog port checks
// Assumes: one clock
// Notes: none
`timescale 1ns/100ps
`default_nettype none
module wwdt_sva (
  // Watched ports
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ctl_wr,
  input wire logic ctl_enable,
  input wire logic [6:0] ctl_count,
  input wire logic active_ff,
  input wire logic [6:0] count_ff,
  input wire logic [6:0] window_ff,
  input wire logic reset_req_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_wr;
    ctl_wr && !reset_req_ff;
  endsequence
  sequence s_early;
    s_wr ##0 active_ff && count_ff >= window_ff;
  endsequence
  a_sw_enable: assert property (s_wr ##0 ctl_enable |=> active_ff)
    else $error("enable lost");
  a_stay_active: assert property (active_ff |=> active_ff)
    else $error("watchdog disabled");
  a_timeout_req: assert property (active_ff && !count_ff[6] |-> reset_req_ff)
    else $error("no timeout reset");
  a_early_req: assert property (s_early |=> reset_req_ff)
    else $error("no early reset");
  a_reload_now: assert property (s_wr ##0 !(active_ff && count_ff >= window_ff) |=>
    count_ff == $past(ctl_count))
    else $error("no reload");
endmodule
bind wwdt_top wwdt_sva u_sva (.clk_sys(clk_sys), .srst(srst), .ctl_wr(ctl_wr),
  .ctl_enable(ctl_enable), .ctl_count(ctl_count), .active_ff(active_ff),
  .count_ff(count_ff), .window_ff(window_ff), .reset_req_ff(reset_req_ff));
`default_nettype wire

//--- tb/wwdt_top_tb.sv
// Purpose: watchdog bench
// Assumes: tick every 4 cycles
// Notes: none
`timescale 1ns/100ps
`default_nettype none
module wwdt_top_tb;
  logic clk_sys = 0, srst = 1, cfg_hw_enable = 0, ctl_wr = 0, ctl_enable = 0, win_wr = 0;
  logic [6:0] ctl_count = 7'h7F, win_value = 7'h7F, count_ff, window_ff;
  logic active_ff, reset_req_ff, timeout_flag_ff, early_flag_ff;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  wwdt_top #(.TICK_CYC(17'h4)) dut (.clk_sys(clk_sys), .srst(srst),
    .cfg_hw_enable(cfg_hw_enable), .ctl_wr(ctl_wr), .ctl_enable(ctl_enable),
    .ctl_count(ctl_count), .win_wr(win_wr), .win_value(win_value),
    .active_ff(active_ff), .count_ff(count_ff), .window_ff(window_ff),
    .reset_req_ff(reset_req_ff), .timeout_flag_ff(timeout_flag_ff),
    .early_flag_ff(early_flag_ff));
  initial forever #4 clk_sys = ~clk_sys;
  task chk(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rst(input logic hw);
    @(negedge clk_sys);
    srst = 1;
    cfg_hw_enable = hw;
    repeat (3) @(negedge clk_sys);
    srst = 0;
    repeat (2) @(negedge clk_sys);
  endtask
  task wr(input logic en, input logic [6:0] c);
    ctl_wr = 1;
    ctl_enable = en;
    ctl_count = c;
    @(negedge clk_sys);
    ctl_wr = 0;
    @(negedge clk_sys);
  endtask
  task wwin(input logic [6:0] w);
    win_wr = 1;
    win_value = w;
    @(negedge clk_sys);
    win_wr = 0;
    @(negedge clk_sys);
  endtask
  task t_strap;
    rst(1);
    chk(active_ff, 1);
    chk(count_ff, 7'h7F);
    chk(reset_req_ff, 0);
  endtask
  task t_timeout;
    rst(0);
    chk(active_ff, 0);
    wr(1, 7'h70);
    chk(active_ff, 1);
    chk(count_ff, 7'h70);
    wr(0, 7'h41);
    chk(active_ff, 1);
    chk(count_ff, 7'h41);
    repeat (4) @(negedge clk_sys);
    chk(count_ff, 7'h40);
    chk(reset_req_ff, 0);
    repeat (5) @(negedge clk_sys);
    chk(count_ff, 7'h3F);
    chk(timeout_flag_ff, 1);
    chk(reset_req_ff, 1);
    chk(early_flag_ff, 0);
    repeat (8) @(negedge clk_sys);
    chk(count_ff, 7'h3F);
  endtask
  task t_early;
    rst(0);
    chk(timeout_flag_ff, 0);
    wwin(7'h50);
    chk(window_ff, 7'h50);
    wr(1, 7'h7F);
    wr(0, 7'h60);
    chk(early_flag_ff, 1);
    chk(reset_req_ff, 1);
    chk(timeout_flag_ff, 0);
    chk(count_ff, 7'h7F);
    wr(1, 7'h10);
    chk(count_ff, 7'h7F);
  endtask
  task t_win_edge;
    rst(0);
    wwin(7'h60);
    wr(1, 7'h60);
    chk(count_ff, 7'h60);
    wr(0, 7'h30);
    chk(early_flag_ff, 1);
    chk(count_ff, 7'h60);
  endtask
  task end_of_test;
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 500)
    begin
      n_fail++;
      end_of_test;
    end
  end
  initial
  begin
    t_strap;
    t_timeout;
    t_early;
    t_win_edge;
    end_of_test;
  end
endmodule
`default_nettype wire
